// *** dv/dmb_chk.sv ***
// Port assertions for the mode-set and burst block.
// Assumes link-side outputs are registered on ck_link.
module dmb_chk #(
  parameter int COL_W = dmb_pkg::COL_W_DEFAULT
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       ck_link,
  input wire logic                       dram_reset_n,
  input wire dmb_pkg::dmb_cmd_t          cmd,
  input wire logic [COL_W-1:0]           beat_col,
  input wire dmb_pkg::dmb_beat_t         beat_info,
  input wire logic                       features_ready,
  input wire logic                       reserved_error,
  input wire logic [dmb_pkg::MODE_W-1:0] base_mode_view,
  input wire logic                       view_update,
  input wire logic                       loop_reset_req
);
  // ==========================================================================
  // Decode
  // ==========================================================================
  wire       mset = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == 4'h0 && cmd.bank == 3'h0;
  wire       rdwr = {cmd.cs_n, cmd.ras_n, cmd.cas_n} == 3'h2;
  wire       rsv  = |{cmd.addr[14:13], cmd.addr[7]};
  wire       act  = beat_info.active;
  wire [2:0] bt   = beat_info.beat;
  // ==========================================================================
  // Properties
  // ==========================================================================
  ready_drop_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    mset |=> !features_ready) else $error("ready kept");
  gap_hold_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    $fell(features_ready) |-> (!features_ready) [*8]) else $error("gap short");
  slot_step_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    act && bt != 3'h7 |=> act && bt == $past(bt) + 3'h1) else $error("slot skip");
  burst_start_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    rdwr && !act && !$past(rdwr) |-> ##2 act && bt == 3'h0) else $error("late start");
  block_keep_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    act && bt < 3'h3 |=> beat_col[COL_W-1:2] == $past(beat_col[COL_W-1:2])) else $error("left nibble");
  write_order_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    act && beat_info.is_write && !bt[2] |-> beat_col[1:0] == bt[1:0]) else $error("write order");
  reserved_flag_a: assert property (@(posedge ck_link) disable iff (!rst_n)
    mset |=> reserved_error == $past(rsv)) else $error("reserved flag");
  view_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(base_mode_view) |-> view_update) else $error("silent change");
  loop_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    loop_reset_req |=> !loop_reset_req) else $error("loop bit stuck");
endmodule

bind dmb_mode_burst dmb_chk #(.COL_W(COL_W)) dmb_chk_i (.clk(clk), .rst_n(rst_n), .ck_link(ck_link),
  .dram_reset_n(dram_reset_n), .cmd(cmd), .beat_col(beat_col), .beat_info(beat_info),
  .features_ready(features_ready), .reserved_error(reserved_error), .base_mode_view(base_mode_view),
  .view_update(view_update), .loop_reset_req(loop_reset_req));

// *** dv/dmb_ctrl_model.sv ***
// Controller stand-in driving the command pins.
// Assumes the bench runs ck_link freely and calls send().
module dmb_ctrl_model (
  input wire logic          ck_link,
  output dmb_pkg::dmb_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK_CK = 512;
  initial cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};
  // ==========================================================================
  // Command issue
  // ==========================================================================
  // Deselected pins toggle so a stale value never passes for a command
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ck_link);
      #1;
      cmd = dmb_pkg::dmb_cmd_t'({1'b1, ~cmd[$bits(dmb_pkg::dmb_cmd_t)-2:0]});
    end
  endtask
  // No supply change, clock enable or termination pin here: held at rest
  // Kind 0 mode-set, 1 read, 2 write; fast skips the gap on purpose
  task automatic send(input logic [1:0] kind, input logic [17:0] v, input logic fast);
    @(posedge ck_link);
    #1;
    cmd = '{1'b0, kind != 2'h0, 1'b0, kind == 2'h1, v[17:15], v[14:0]};
    idle(fast ? 1 : (kind == 2'h0 ? 14 : 11));
    if (kind == 2'h0 && v[8]) idle(LOCK_CK);
  endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the mode-set and burst block.
// Assumes the controller model owns the command pins.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int COL_W = 10;
  logic                       clk, rst_n, ck_link, dram_reset_n, ch;
  logic                       features_ready, reserved_error, view_update, loop_reset_req;
  dmb_pkg::dmb_cmd_t          cmd;
  dmb_pkg::dmb_beat_t         beat_info;
  logic [COL_W-1:0]           beat_col;
  logic [COL_W-1:0]           cols [8];
  logic [7:0]                 drv;
  logic [dmb_pkg::MODE_W-1:0] base_mode_view;
  int                         n_errors, num_checks, nslot, nloop, nupd;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

  dmb_mode_burst #(.COL_W(COL_W)) dmb_mode_burst_i (.clk(clk), .rst_n(rst_n), .ck_link(ck_link),
    .dram_reset_n(dram_reset_n), .cmd(cmd), .beat_col(beat_col), .beat_info(beat_info),
    .features_ready(features_ready), .reserved_error(reserved_error), .base_mode_view(base_mode_view),
    .view_update(view_update), .loop_reset_req(loop_reset_req));
  dmb_ctrl_model dmb_ctrl_model_i (.ck_link(ck_link), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    ck_link = 1'b0;
    #7;
    forever #62.5 ck_link = ~ck_link;
  end
  always @(negedge ck_link) if (beat_info.active === 1'b1) begin
    cols[beat_info.beat] = beat_col;
    drv[beat_info.beat] = beat_info.drive;
    nslot++;
  end
  always @(posedge clk) if (loop_reset_req === 1'b1) nloop++;
  always @(posedge clk) if (view_update === 1'b1) nupd++;
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [2:0] order(input logic [2:0] s, k, input logic ilv, wr, c);
    if (wr) return c ? {s[2], k[1:0]} : k;
    if (ilv) return s ^ k;
    return {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction
  task automatic burst(input logic [1:0] kind, input logic [14:0] a, input logic ilv, c);
    nslot = 0;
    dmb_ctrl_model_i.send(kind, {3'h0, a}, 1'b0);
    `CHK("slots", 8, nslot)
    for (int k = 0; k < 8; k++) begin
      if (k < 4 || !c) `CHK("col", {a[COL_W-1:3], order(a[2:0], k[2:0], ilv, kind == 2'h2, c)}, cols[k])
      if (kind == 2'h1) `CHK("drive", !(c && k > 3), drv[k])
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    dram_reset_n = 1'b1;
    // Link side resets through a synchroniser, so it needs link edges too
    repeat (16) @(posedge clk);
    repeat (3) @(posedge ck_link);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("ready", 1'b1, features_ready)
    `CHK("view", 18'h00000, base_mode_view)
    dmb_ctrl_model_i.idle(3);
    for (int m = 0; m < 8; m++) begin
      dmb_ctrl_model_i.send(2'h0, {14'h0000, m[2], 1'b0, m[1:0]}, 1'b0);
      repeat (10) @(posedge clk);
      `CHK("view", {14'h0000, m[2], 1'b0, m[1:0]}, base_mode_view)
      for (int s = 0; s < 16; s++) begin
        ch = m[1:0] == 2'h2 || (m[1:0] == 2'h1 && !s[3]);
        burst(2'h1, {2'h0, s[3], 2'h0, 3'h5, s[3:0], s[2:0]}, m[2], ch);
        burst(2'h2, {2'h0, s[3], 2'h0, 3'h2, s[3:0], s[2:0]}, m[2], ch);
      end
    end
    // Read inside the gap still sees the old interleaved order
    dmb_ctrl_model_i.send(2'h0, 18'h00000, 1'b1);
    `CHK("ready", 1'b0, features_ready)
    burst(2'h1, 15'h0001, 1'b1, 1'b0);
    dmb_ctrl_model_i.idle(4);
    `CHK("ready", 1'b1, features_ready)
    burst(2'h1, 15'h0001, 1'b0, 1'b0);
    dmb_ctrl_model_i.send(2'h0, 18'h00180, 1'b0);
    `CHK("loop", 1, nloop)
    `CHK("rsv", 1'b1, reserved_error)
    `CHK("view", 18'h00080, base_mode_view)
    dmb_ctrl_model_i.send(2'h0, 18'h00009, 1'b0);
    `CHK("rsv", 1'b0, reserved_error)
    @(posedge clk);
    #1;
    nupd = 0;
    dram_reset_n = 1'b0;
    repeat (4) @(posedge ck_link);
    #1;
    dram_reset_n = 1'b1;
    repeat (10) @(posedge clk);
    `CHK("view", 18'h00000, base_mode_view)
    `CHK("update", 1, nupd)
    `CHK("loop", 1, nloop)
    burst(2'h1, 15'h0003, 1'b0, 1'b0);
    give_verdict();
  end
  initial begin
    #1500000;
    n_errors++;
    give_verdict();
  end
endmodule

// *** rtl/dmb_mode_burst.sv ***
// Mode-set decode, base mode register and burst column ordering.
// Assumes command pins are driven by the controller on ck_link; rst_n and the
// configuration view run on clk, unrelated in phase to ck_link.
// How it works
// - Mode register holds; loop-reset bit self-clears
// - New settings take effect after other gap
// - On-the-fly: address bit twelve picks length
// - Burst wraps inside aligned column block
// - Bit three selects burst order type
// - Sequential: rotate nibble, then other nibble
// - Interleaved: column is start xor beat
// - Chop read tri-states last four slots
// - Writes ignore low start bits
// - Chop starts same clock as full burst
module dmb_mode_burst #(
  parameter int COL_W = dmb_pkg::COL_W_DEFAULT
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ck_link,
  input  wire logic                        dram_reset_n,
  input  wire dmb_pkg::dmb_cmd_t           cmd,
  output logic [COL_W-1:0]                 beat_col,
  output dmb_pkg::dmb_beat_t               beat_info,
  output logic                             features_ready,
  output logic                             reserved_error,
  output logic [dmb_pkg::MODE_W-1:0]       base_mode_view,
  output logic                             view_update,
  output logic                             loop_reset_req
);

  // ==========================================================================
  // Link domain reset: rst_n and the reset pin, synchronised into ck_link
  // ==========================================================================
  logic lrst_s1;
  logic lrst_s2;
  logic lrst_s3;
  logic srst_s1;
  logic srst_s2;

  always_ff @(posedge ck_link) begin
    lrst_s1 <= rst_n & dram_reset_n;
    lrst_s2 <= lrst_s1;
    lrst_s3 <= lrst_s2;
  end

  // The event toggles follow rst_n only: the reset pin must not fake a
  // loop-reset request or hide a settings change from the clk side.
  always_ff @(posedge ck_link) begin
    srst_s1 <= rst_n;
    srst_s2 <= srst_s1;
  end

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic is_mode_set;
  logic is_read;
  logic is_write;

  always_comb begin
    is_mode_set = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
    is_read     = ~cmd.cs_n &  cmd.ras_n & ~cmd.cas_n &  cmd.we_n;
    is_write    = ~cmd.cs_n &  cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
  end

  logic [dmb_pkg::MODE_W-1:0] mode_word;
  logic                       hit_base;

  always_comb begin
    mode_word = {cmd.bank, cmd.addr};
    hit_base  = is_mode_set && (cmd.bank == dmb_pkg::SEL_BASE);
  end

  // ==========================================================================
  // Base mode register and the settings in force
  // ==========================================================================
  logic [dmb_pkg::MODE_W-1:0] base_mode_config;
  logic [dmb_pkg::MODE_W-1:0] active_cfg;
  logic [dmb_pkg::GAP_W-1:0]  gap_cnt;
  logic                       loop_tgl;
  logic                       cfg_tgl;
  logic [dmb_pkg::MODE_W-1:0] cfg_hold;

  // The loop-reset bit is stored for the one cycle that starts the relock,
  // then drops; the other fields stay until rewritten or reset.
  always_ff @(posedge ck_link) begin
    if (!lrst_s2) begin
      base_mode_config <= dmb_pkg::MODE_RESET;
      reserved_error   <= 1'b0;
    end else if (hit_base) begin
      base_mode_config <= mode_word;
      reserved_error   <= |(mode_word & dmb_pkg::RESERVED_MASK);
    end else begin
      base_mode_config[dmb_pkg::DLL_RESET_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ck_link) begin
    if (!srst_s2) begin
      loop_tgl <= 1'b0;
    end else if (lrst_s2 && hit_base && mode_word[dmb_pkg::DLL_RESET_BIT]) begin
      loop_tgl <= ~loop_tgl;
    end
  end

  // Entering a link reset from the reset pin flips the toggle too, so the clk side drops its
  // copy of the old settings instead of keeping it until the next mode-set.
  always_ff @(posedge ck_link) begin
    if (!srst_s2) begin
      cfg_tgl <= 1'b0;
    end else if (lrst_s3 && !lrst_s2) begin
      cfg_tgl <= ~cfg_tgl;
    end else if (lrst_s2 && !hit_base && gap_cnt == '0 && !features_ready) begin
      cfg_tgl <= ~cfg_tgl;
    end
  end

  // Updated fields stay out of force until the gap has run out, so a burst
  // issued early is ordered by the old settings.
  always_ff @(posedge ck_link) begin
    if (!lrst_s2) begin
      gap_cnt        <= '0;
      active_cfg     <= dmb_pkg::MODE_RESET;
      features_ready <= 1'b1;
      cfg_hold       <= dmb_pkg::MODE_RESET;
    end else if (hit_base) begin
      gap_cnt        <= dmb_pkg::GAP_W'(dmb_pkg::MODE_TO_OTHER_GAP_CK - 1);
      features_ready <= 1'b0;
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - 1'b1;
    end else if (!features_ready) begin
      active_cfg     <= base_mode_config;
      features_ready <= 1'b1;
      cfg_hold       <= base_mode_config;
    end
  end

  // ==========================================================================
  // Burst engine: eight slots per read or write, chop or not
  // ==========================================================================
  logic [1:0] bl_field;
  logic       chop;
  logic       interleave;

  always_comb begin
    bl_field   = active_cfg[dmb_pkg::BL_LSB +: 2];
    interleave = active_cfg[dmb_pkg::BT_BIT];
    case (bl_field)
      dmb_pkg::BL_FIXED8: chop = 1'b0;
      dmb_pkg::BL_OTF:    chop = ~cmd.addr[dmb_pkg::CHOP_SEL_BIT];
      dmb_pkg::BL_CHOP4:  chop = 1'b1;
      default:            chop = 1'b0;
    endcase
  end

  // Column of beat k from a three-bit start
  function automatic logic [2:0] order_col(input logic [2:0] start, input logic [2:0] k,
                                           input logic ilv, input logic wr, input logic ch);
    logic [1:0] rot;
    rot = start[1:0] + k[1:0];
    if (wr) begin
      order_col = ch ? {start[2], k[1:0]} : k;
    end else if (ilv) begin
      order_col = start ^ k;
    end else begin
      order_col = {start[2] ^ k[2], rot};
    end
  endfunction

  logic             busy;
  logic [2:0]       slot;
  logic [2:0]       start_q;
  logic [COL_W-4:0] block_q;
  logic             chop_q;
  logic             wr_q;
  logic             ilv_q;

  always_ff @(posedge ck_link) begin
    if (!lrst_s2) begin
      busy    <= 1'b0;
      slot    <= '0;
      start_q <= '0;
      block_q <= '0;
      chop_q  <= 1'b0;
      wr_q    <= 1'b0;
      ilv_q   <= 1'b0;
    end else if (!busy && (is_read || is_write)) begin
      busy    <= 1'b1;
      slot    <= '0;
      start_q <= cmd.addr[2:0];
      block_q <= cmd.addr[COL_W-1:3];
      chop_q  <= chop;
      wr_q    <= is_write;
      ilv_q   <= interleave;
    end else if (busy) begin
      slot <= slot + 1'b1;
      busy <= (slot != 3'(dmb_pkg::BURST_SLOTS - 1));
    end
  end

  always_ff @(posedge ck_link) begin
    if (!lrst_s2) begin
      beat_col  <= '0;
      beat_info <= '0;
    end else begin
      beat_col         <= {block_q, order_col(start_q, slot, ilv_q, wr_q, chop_q)};
      beat_info.active <= busy;
      beat_info.drive  <= busy && !wr_q && !(chop_q && slot[2]);
      beat_info.is_write <= busy && wr_q;
      beat_info.beat   <= slot;
    end
  end

  // ==========================================================================
  // Crossing to clk: toggles carry events, the held word is stable meanwhile
  // ==========================================================================
  logic [2:0] cfg_sync;
  logic [2:0] loop_sync;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_sync  <= '0;
      loop_sync <= '0;
    end else begin
      cfg_sync  <= {cfg_sync[1:0], cfg_tgl};
      loop_sync <= {loop_sync[1:0], loop_tgl};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_mode_view <= dmb_pkg::MODE_RESET;
      view_update    <= 1'b0;
      loop_reset_req <= 1'b0;
    end else begin
      view_update    <= cfg_sync[2] ^ cfg_sync[1];
      loop_reset_req <= loop_sync[2] ^ loop_sync[1];
      if (cfg_sync[2] ^ cfg_sync[1]) begin
        base_mode_view <= cfg_hold;
      end
    end
  end

endmodule

// *** shared/dmb_pkg.sv ***
// Constants and types for the mode-set and burst-ordering block.
// Assumes the controller drives command pins synchronous to the link clock.
package dmb_pkg;

  // ==========================================================================
  // Widths and field positions of the base mode register
  // ==========================================================================
  localparam int MODE_W         = 18;
  localparam int ADDR_W         = 15;
  localparam int BANK_W         = 3;
  localparam int COL_W_DEFAULT  = 10;
  localparam int BL_LSB         = 0;
  localparam int BT_BIT         = 3;
  localparam int DLL_RESET_BIT  = 8;
  localparam int CHOP_SEL_BIT   = 12;
  localparam int SEL_LSB        = 15;
  localparam logic [MODE_W-1:0] MODE_RESET    = 18'h00000;
  localparam logic [MODE_W-1:0] RESERVED_MASK = 18'h26080;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP4  = 2'h2;
  localparam logic [2:0] SEL_BASE  = 3'h0;

  // ==========================================================================
  // Timing counts, in link clock cycles
  // ==========================================================================
  localparam int MODE_TO_MODE_GAP_CK  = 4;
  localparam int MODE_TO_OTHER_GAP_CK = 12;
  localparam int BURST_SLOTS          = 8;
  localparam int GAP_W                = 4;

  // ==========================================================================
  // Command pins as sampled on the link clock
  // ==========================================================================
  typedef struct packed {
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } dmb_cmd_t;

  // One beat slot of an internal burst
  typedef struct packed {
    logic        active;
    logic        drive;
    logic        is_write;
    logic [2:0]  beat;
  } dmb_beat_t;

endpackage
